/* hw/txs_core.sv */
// txs_core: executes table write, table read mode, skip-if-zero, both xors
// and the extended pointer-arith-with-return enable, one opcode per bus write
// assumes a wishbone master; operand register value supplied via FREG
//
// Summary of operation
// - table write opcode, mode field picks update
// - pointer low three bits pick holding register
// - table write loads holding registers only
// - pointer is 21-bit byte address
// - pointer bit zero selects low/high byte
// - skip next instruction when register zero
// - skip takes one, two or three cycles
// - access bit zero selects access bank
// - access bit one uses bank select
// - extended, access, address <=95: indexed offset; here only flagged in status, the operand address is not offset
// - xor literal into accumulator, one cycle
// - xors touch only negative and zero
// - xor file, destination bit picks target
// - extended set off after reset
// - extension adds eight literal pointer instructions; only the add/subtract pointer forms are decoded here
// - pointer-2 arith forms also return
// - table read shares prefix, same modes
//
// Local design decisions: the register offsets and the Wishbone register port.
module txs_core
  import txs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire txs_wb_req_t wb_req,
  output txs_wb_rsp_t      wb_rsp,
  output logic [7:0]       freg_wdata,
  output logic             freg_we,
  output logic             ret_pulse,
  output logic             prog_byte_hi
);
  ////////////////////////////////////////////////////////////////////////////
  // state and storage
  typedef enum logic [1:0] {
    TXS_S_IDLE = 2'b00,
    TXS_S_EXEC = 2'b01,
    TXS_S_DONE = 2'b10
  } txs_state_t;
  txs_state_t  st_reg, st_next;           // sequencer
  logic [1:0]  cyc_left_reg;              // instruction cycles remaining
  logic [15:0] op_reg;                    // opcode being executed
  logic [7:0]  acc_reg;                   // accumulator
  logic [7:0]  freg_reg;                  // operand register value
  logic [20:0] ptr_reg;                   // table pointer
  logic [7:0]  latch_reg;                 // table latch
  logic [7:0]  hold_reg [TXS_HOLD_N];     // holding registers, never program memory
  logic [7:0]  bank_reg;                  // bank select
  logic        ext_en_reg;                // extended set enable
  logic        nextw_reg;                 // following insn is two words
  logic [7:0]  stat_reg;                  // flags and last-result info
  logic [11:0] faddr_reg;                 // operand address of the last opcode
  logic        ack_reg;                   // bus answer
  logic [31:0] rdat_reg;                  // bus read data
  logic [7:0]  fwd_reg;                   // file write data
  logic        fwe_reg;                   // file write strobe
  logic        ret_reg;                   // return strobe
  logic [1:0]  q;                         // quarter
  logic        q4;                        // last quarter

  txs_quarter u_q (
    .clk  (clk),
    .nrst (nrst),
    .q    (q),
    .q4   (q4)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire bus_go   = wb_req.cyc && wb_req.stb && !ack_reg;
  wire wr_go    = bus_go && wb_req.we && wb_req.sel[0];
  wire insn_wr  = wr_go && wb_req.adr == TXS_A_INSN;
  // a new opcode waits while one runs; ack stalls until then
  wire bus_take = bus_go && !(insn_wr && st_reg != TXS_S_IDLE);
  wire [7:0] wlo = wb_req.dat[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // opcode decode, on the opcode being taken
  wire [15:0] op     = wb_req.dat[15:0];
  // the whole word above the mode field must match, mode bits are free
  wire is_table_write_op = op[15:2] == TXS_OP_TABLE_WRITE_OP_BASE[15:2];
  wire is_table_read_op = op[15:2] == TXS_OP_TABLE_READ_OP_BASE[15:2];
  wire is_tst   = op[15:9] == TXS_OP_TST_HI;
  wire is_xorl  = op[15:8] == TXS_OP_XORL_HI;
  wire is_xorf  = op[15:10] == TXS_OP_XORF_HI;
  // extended literal ops exist only with the enable set
  wire is_farith = ext_en_reg && op[15:9] == TXS_OP_FSRARITH;
  wire is_ulnk   = is_farith && op[7:6] == TXS_FSR2_SEL;
  // file operand addressing mode
  wire acc_bit  = op[8];
  wire ilo_mode = !acc_bit && ext_en_reg && op[7:0] <= TXS_ILO_MAX;
  // access bank when a=0 otherwise bank select forms the address
  wire [11:0] faddr = acc_bit ? {bank_reg[3:0], op[7:0]}
                              : {{4{op[7]}}, op[7:0]};

  ////////////////////////////////////////////////////////////////////////////
  // pointer update for the opcode held in execution
  logic [20:0] ptr_nx, ptr_use;
  txs_ptr_upd u_pu (
    .ptr      (ptr_reg),
    .mode     (op_reg[1:0]),
    .next_ptr (ptr_nx),
    .use_ptr  (ptr_use)
  );
  wire exec_wt = op_reg[15:2] == TXS_OP_TABLE_WRITE_OP_BASE[15:2];
  wire exec_rd = op_reg[15:2] == TXS_OP_TABLE_READ_OP_BASE[15:2];
  // finish at Q4 of the last instruction cycle
  wire last_q4 = st_reg == TXS_S_EXEC && q4 && cyc_left_reg == 2'h1;

  // results
  wire [7:0] xl_res  = acc_reg ^ op[7:0];
  wire [7:0] xf_res  = acc_reg ^ freg_reg;
  wire [7:0] x_res   = is_xorl ? xl_res : xf_res;
  wire       skip    = freg_reg == 8'h00;
  // cycles: table ops 2, skip 1/2/3, ulnk 2, others 1
  wire [1:0] n_cyc = (is_table_write_op || is_table_read_op || is_ulnk) ? 2'h2 :
                     (is_tst && skip) ? (nextw_reg ? 2'h3 : 2'h2) : 2'h1;
  wire known = is_table_write_op || is_table_read_op || is_tst || is_xorl || is_xorf || is_farith;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      TXS_S_IDLE: if (insn_wr) st_next = TXS_S_EXEC;
      TXS_S_EXEC: if (last_q4) st_next = TXS_S_DONE;
      TXS_S_DONE: st_next = TXS_S_IDLE;
      default:    st_next = TXS_S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) st_reg <= TXS_S_IDLE;
    else       st_reg <= st_next;
  end

  // cycle counter, counted down at each Q4
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)                                cyc_left_reg <= 2'h0;
    else if (insn_wr && st_reg == TXS_S_IDLE) cyc_left_reg <= n_cyc;
    else if (st_reg == TXS_S_EXEC && q4)      cyc_left_reg <= cyc_left_reg - 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // execution and register writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_reg     <= 16'h0000;
      acc_reg    <= 8'h00;
      freg_reg   <= 8'h00;
      ptr_reg    <= 21'h000000;
      latch_reg  <= 8'h00;
      bank_reg   <= 8'h00;
      ext_en_reg <= 1'b0;                                 // off after reset
      nextw_reg  <= 1'b0;
      stat_reg   <= 8'h00;
      faddr_reg  <= 12'h000;
      fwd_reg    <= 8'h00;
      fwe_reg    <= 1'b0;
      ret_reg    <= 1'b0;
      for (int i = 0; i < TXS_HOLD_N; i++) hold_reg[i] <= 8'h00;
    end else begin
      fwe_reg <= 1'b0;
      ret_reg <= 1'b0;
      if (insn_wr && st_reg == TXS_S_IDLE) begin
        op_reg                <= op;
        faddr_reg             <= faddr;
        stat_reg[TXS_ST_BUSY] <= 1'b1;
        stat_reg[TXS_ST_ILL]  <= !known;
        stat_reg[TXS_ST_SKIP] <= is_tst && skip;
        stat_reg[TXS_ST_ILO]  <= (is_tst || is_xorf) && ilo_mode;
        stat_reg[TXS_ST_RET]  <= is_ulnk;
        stat_reg[TXS_ST_FWR]  <= is_xorf && op[9];
        if (is_xorl || is_xorf) begin
          stat_reg[TXS_ST_N] <= x_res[7];                 // only N and Z
          stat_reg[TXS_ST_Z] <= x_res == 8'h00;
        end
        if (is_xorl) acc_reg <= xl_res;
        if (is_xorf && !op[9]) acc_reg <= xf_res;         // d=0 to accumulator
        if (is_xorf && op[9]) begin                       // d=1 back to register
          freg_reg <= xf_res;
          fwd_reg  <= xf_res;
          fwe_reg  <= 1'b1;
        end
        if (is_ulnk) ret_reg <= 1'b1;                     // return pulse the cycle after take
      end else if (wr_go && st_reg == TXS_S_IDLE) begin
        case (wb_req.adr)
          TXS_A_CTRL:  ext_en_reg <= wlo[0];
          TXS_A_ACC:   acc_reg    <= wlo;
          TXS_A_FREG:  freg_reg   <= wlo;
          TXS_A_PTR:   ptr_reg    <= wb_req.dat[20:0];
          TXS_A_LATCH: latch_reg  <= wlo;
          TXS_A_BANK:  bank_reg   <= wlo;
          TXS_A_NEXTW: nextw_reg  <= wlo[0];
          default: ;
        endcase
      end
      // table write: latch to holding reg at final Q4
      if (last_q4 && exec_wt) begin
        hold_reg[ptr_use[2:0]] <= latch_reg;
        ptr_reg                <= ptr_nx;
      end
      // table read: only the pointer mode is handled here
      if (last_q4 && exec_rd) ptr_reg <= ptr_nx;
      if (last_q4) stat_reg[TXS_ST_BUSY] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    case (wb_req.adr)
      TXS_A_CTRL:   rmux = {31'h0, ext_en_reg};
      // upper half shows the formed operand address so software can see banking
      TXS_A_INSN:   rmux = {4'h0, faddr_reg, op_reg};
      TXS_A_ACC:    rmux = {24'h0, acc_reg};
      TXS_A_FREG:   rmux = {24'h0, freg_reg};
      TXS_A_PTR:    rmux = {11'h0, ptr_reg};
      TXS_A_LATCH:  rmux = {24'h0, latch_reg};
      TXS_A_STATUS: rmux = {24'h0, stat_reg};
      TXS_A_BANK:   rmux = {24'h0, bank_reg};
      TXS_A_NEXTW:  rmux = {31'h0, nextw_reg};
      default: begin
        // holding registers at 0x20..0x3C, unmapped reads zero
        if (wb_req.adr[7:5] == 3'h1 && wb_req.adr[1:0] == 2'h0)
          rmux = {24'h0, hold_reg[wb_req.adr[4:2]]};
      end
    endcase
  end

  // ack one cycle after take, dropped next cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg  <= bus_take;
      rdat_reg <= rmux;
    end
  end

  assign wb_rsp.ack   = ack_reg;
  assign wb_rsp.dat   = rdat_reg;
  assign freg_wdata   = fwd_reg;
  assign freg_we      = fwe_reg;
  assign ret_pulse    = ret_reg;
  assign prog_byte_hi = ptr_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  xor_flags_a: assert property (@(posedge clk) disable iff (!nrst)
    insn_wr && st_reg == TXS_S_IDLE && is_xorl |=> stat_reg[TXS_ST_Z] == (acc_reg == 8'h00))
    else $error("xor zero flag wrong");
  xorl_acc_a: assert property (@(posedge clk) disable iff (!nrst)
    insn_wr && st_reg == TXS_S_IDLE && is_xorl |=> acc_reg == ($past(acc_reg) ^ $past(op[7:0])))
    else $error("xor literal result wrong");
  xorf_dest_a: assert property (@(posedge clk) disable iff (!nrst)
    insn_wr && st_reg == TXS_S_IDLE && is_xorf && op[9] |=> freg_we && acc_reg == $past(acc_reg))
    else $error("xor file destination wrong");
  ext_reset_a: assert property (@(posedge clk) $rose(nrst) |-> !ext_en_reg)
    else $error("extended set on after reset");
  ulnk_ret_a: assert property (@(posedge clk) disable iff (!nrst)
    ret_pulse |-> $past(is_ulnk && insn_wr))
    else $error("return without pointer op");
  table_write_op_len_a: assert property (@(posedge clk) disable iff (!nrst)
    insn_wr && st_reg == TXS_S_IDLE && is_table_write_op |=> ##[4:8] st_reg == TXS_S_DONE)
    else $error("table write length wrong");
  skip_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    insn_wr && st_reg == TXS_S_IDLE && is_tst |=> stat_reg[TXS_ST_SKIP] == ($past(freg_reg) == 8'h00))
    else $error("skip decision wrong");
  skip_cyc_a: assert property (@(posedge clk) disable iff (!nrst)
    insn_wr && st_reg == TXS_S_IDLE && is_tst && skip && nextw_reg |=> cyc_left_reg == 2'h3)
    else $error("skip cycle count wrong");
  ptr_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    last_q4 && exec_wt && op_reg[1:0] == 2'h0 |=> ptr_reg == $past(ptr_reg))
    else $error("pointer moved in no-change mode");
  cov_table_write_op_c: cover property (@(posedge clk) last_q4 && exec_wt);
  cov_skip_c: cover property (@(posedge clk) insn_wr && is_tst && skip);
  cov_ulnk_c: cover property (@(posedge clk) ret_pulse);
endmodule

/* pkg/txs_pkg.sv */
// txs_pkg: shared constants and carriers for the table write / xor / skip slice
// assumes one 100 MHz clock and a classic wishbone register port
package txs_pkg;
  // opcode patterns
  localparam logic [15:0] TXS_OP_TABLE_WRITE_OP_BASE = 16'h000C; // table write, low 2 bits = mode
  localparam logic [15:0] TXS_OP_TABLE_READ_OP_BASE = 16'h0008; // table read, low 2 bits = mode
  localparam logic [13:0] TXS_OP_TBL_HI     = 14'h0000; // shared upper bits of table ops
  localparam logic [6:0]  TXS_OP_TST_HI     = 7'h33;    // 0110 011 then a bit
  localparam logic [7:0]  TXS_OP_XORL_HI    = 8'h0A;    // xor literal prefix
  localparam logic [5:0]  TXS_OP_XORF_HI    = 6'h06;    // 0001 10 then d, a
  localparam logic [6:0]  TXS_OP_FSRARITH   = 7'h74;    // 1110 100 then sub bit
  localparam logic [1:0]  TXS_FSR2_SEL      = 2'h3;     // ff = 11 means pointer 2 with return
  localparam logic [7:0]  TXS_ILO_MAX       = 8'h5F;    // 95, highest indexed offset
  localparam int          TXS_STD_COUNT     = 75;       // standard instructions
  localparam int          TXS_EXT_COUNT     = 8;        // extended instructions
  // pointer update modes
  typedef enum logic [1:0] {
    TXS_PM_NONE    = 2'b00,
    TXS_PM_POSTINC = 2'b01,
    TXS_PM_POSTDEC = 2'b10,
    TXS_PM_PREINC  = 2'b11
  } txs_pmode_t;
  localparam int TXS_PTR_W  = 21; // byte pointer width, 2 MByte
  localparam int TXS_HOLD_N = 8;  // holding registers
  // register offsets (byte addresses)
  localparam logic [7:0] TXS_A_CTRL   = 8'h00; // [0] extended enable
  localparam logic [7:0] TXS_A_INSN   = 8'h04; // write: execute opcode
  localparam logic [7:0] TXS_A_ACC    = 8'h08; // accumulator
  localparam logic [7:0] TXS_A_FREG   = 8'h0C; // addressed register operand value
  localparam logic [7:0] TXS_A_PTR    = 8'h10; // table pointer
  localparam logic [7:0] TXS_A_LATCH  = 8'h14; // table latch
  localparam logic [7:0] TXS_A_STATUS = 8'h18; // flags and last-result info
  localparam logic [7:0] TXS_A_HOLD0  = 8'h20; // holding regs 0x20..0x3C
  localparam logic [7:0] TXS_A_BANK   = 8'h40; // bank select
  localparam logic [7:0] TXS_A_NEXTW  = 8'h44; // [0] next insn is two-word
  localparam int TXS_ST_N = 0, TXS_ST_Z = 1, TXS_ST_SKIP = 2, TXS_ST_RET = 3;
  localparam int TXS_ST_ILO = 4, TXS_ST_FWR = 5, TXS_ST_BUSY = 6, TXS_ST_ILL = 7;
  // wishbone carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } txs_wb_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } txs_wb_rsp_t;
endpackage

/* hw/txs_quarter.sv */
// txs_quarter: quarter-cycle phase generator, Q1..Q4 repeating
// assumes clk drives one quarter per edge
module txs_quarter (
  input  wire logic       clk,
  input  wire logic       nrst,
  output logic [1:0]      q,
  output logic            q4
);
  logic [1:0] q_reg;   // current quarter, 0 = Q1
  // free running phase counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) q_reg <= 2'h0;
    else       q_reg <= q_reg + 2'h1;
  end
  assign q  = q_reg;
  assign q4 = (q_reg == 2'h3);
endmodule

/* hw/txs_ptr_upd.sv */
// txs_ptr_upd: table pointer update by mode
// assumes the caller addresses with use_ptr and loads next_ptr in the same step
module txs_ptr_upd
  import txs_pkg::*;
(
  input  wire logic [20:0] ptr,
  input  wire logic [1:0]  mode,
  output logic [20:0]      next_ptr,
  output logic [20:0]      use_ptr
);
  // wraps across the 2 MByte range, no carry out
  assign next_ptr = (mode == TXS_PM_POSTINC || mode == TXS_PM_PREINC) ? ptr + 21'h1 :
                    (mode == TXS_PM_POSTDEC) ? ptr - 21'h1 : ptr;
  // pre-increment addresses the updated value
  assign use_ptr  = (mode == TXS_PM_PREINC) ? next_ptr : ptr;
endmodule

/* bench/tb_top.sv */
// tb_top: self-checking bench for the table write, xor and skip core
// assumes txs_core behind classic wishbone and one 100 MHz clock
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import txs_pkg::*;
  logic        clk;          // core clock
  logic        nrst;         // async reset, active low
  txs_wb_req_t req;          // bus request driven by the bench
  txs_wb_rsp_t rsp;          // bus answer
  logic [7:0]  fw_data;      // write-back value
  logic        fw_we;        // write-back strobe
  logic        ret_p;        // return pulse
  logic        byte_hi;      // pointer bit zero
  int          mismatches, compares, cycles, fw_cnt, ret_cnt, k, f;
  logic [7:0]  fw_last;      // last write-back seen
  logic [31:0] v;            // read data
  logic [20:0] np, hp;       // expected pointer and holding index source
  logic [7:0]  e;            // expected xor result
  logic [20:0] tp [6] = '{21'h00A356, 21'h00A356, 21'h00A356, 21'h01389A, 21'h1FFFFF, 21'h0};
  logic [1:0]  tm [6] = '{2'd0, 2'd1, 2'd2, 2'd3, 2'd1, 2'd2};
  logic [7:0]  xa [3] = '{8'hB5, 8'h0F, 8'h3C};
  logic [7:0]  xk [3] = '{8'hAF, 8'hF0, 8'h3C};
  logic [9:0]  ix [4] = '{{2'b00, 8'h10}, {2'b10, 8'h5F}, {2'b10, 8'h60}, {2'b11, 8'h10}};
  logic [11:0] fa [4] = '{12'h010, 12'h05F, 12'h060, 12'h510}; // bank select 5
  logic [9:0]  fr [4] = '{{2'b10, 8'hC5}, {2'b11, 8'hC5}, {2'b10, 8'h05}, {2'b00, 8'hC5}};

  txs_core uut (.clk(clk), .nrst(nrst), .wb_req(req), .wb_rsp(rsp), .freg_wdata(fw_data),
                .freg_we(fw_we), .ret_pulse(ret_p), .prog_byte_hi(byte_hi));

  ////////////////////////////////////////////////////////////////////////////
  // clock, and a monitor sampling pulses mid-cycle where they are settled
  initial clk = 1'b0;
  always #5ns clk = ~clk;
  always @(negedge clk) begin
    cycles++;
    if (fw_we === 1'b1) begin
      fw_cnt++;
      fw_last = fw_data;
    end
    if (ret_p === 1'b1) ret_cnt++;
    // hang guard: the whole run needs well under a thousand cycles
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one classic cycle; ack is looked at mid-cycle, so the release edge is its edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: d};
    do begin
      @(negedge clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      mismatches++;
      $display("[FAIL] %0t no ack", $time);
    end
    r = rsp.dat;
    @(posedge clk);
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 4'hF, x);
  endtask
  // issue an opcode, then poll until the core is idle again
  task automatic run(input logic [15:0] op);
    int n;
    n = 0;
    wr(TXS_A_INSN, {16'h0000, op});
    do begin
      bus(1'b0, TXS_A_STATUS, 32'h0, 4'hF, v);
      n++;
    end while (v[TXS_ST_BUSY] !== 1'b0 && n < 20);
    if (n >= 20) begin
      mismatches++;
      $display("[FAIL] %0t core stays busy", $time);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    nrst = 1'b0;
    req  = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, TXS_A_CTRL, 32'h0, 4'hF, v);
    `CHK(v[0], 1'b0)
    `CHK(byte_hi, 1'b0)
    bus(1'b0, 8'h7C, 32'h0, 4'hF, v);
    `CHK(v, 32'h0)
    // ignored narrow write leaves the accumulator alone
    wr(TXS_A_ACC, 32'h11);
    bus(1'b1, TXS_A_ACC, 32'h22, 4'h0, v);
    bus(1'b0, TXS_A_ACC, 32'h0, 4'hF, v);
    `CHK(v[7:0], 8'h11)
    // table write and table read over every pointer mode, wrap at 21 bits
    for (f = 1; f >= 0; f--) begin
      for (k = 0; k < 6; k++) begin
        wr(TXS_A_PTR, {11'h0, tp[k]});
        wr(TXS_A_LATCH, 32'h50 + k);
        run({12'h000, 1'b1, f[0], tm[k]});
        hp = (tm[k] == 2'd3) ? tp[k] + 21'h1 : tp[k];
        np = (tm[k] == 2'd2) ? tp[k] - 21'h1 : (tm[k] == 2'd0 ? tp[k] : tp[k] + 21'h1);
        bus(1'b0, TXS_A_PTR, 32'h0, 4'hF, v);
        `CHK(v[20:0], np)
        `CHK(byte_hi, np[0])
        if (f == 1) begin
          bus(1'b0, TXS_A_HOLD0 + {3'h0, hp[2:0], 2'b00}, 32'h0, 4'hF, v);
          `CHK(v[7:0], 8'h50 + k[7:0])
        end
      end
    end
    // both xor forms, flags from the result
    for (f = 0; f < 2; f++) begin
      for (k = 0; k < 3; k++) begin
        e = xa[k] ^ xk[k];
        wr(TXS_A_ACC, {24'h0, xa[k]});
        wr(TXS_A_FREG, {24'h0, xk[k]});
        if (f == 0) run({TXS_OP_XORL_HI, xk[k]});
        else run({TXS_OP_XORF_HI, 1'b0, 1'b1, 8'h20});
        `CHK(v[TXS_ST_N], e[7])
        `CHK(v[TXS_ST_Z], e == 8'h00)
        bus(1'b0, TXS_A_ACC, 32'h0, 4'hF, v);
        `CHK(v[7:0], e)
      end
    end
    // file destination: write-back strobe, accumulator kept
    k = fw_cnt;
    wr(TXS_A_ACC, 32'hB5);
    wr(TXS_A_FREG, 32'hAF);
    run({TXS_OP_XORF_HI, 1'b1, 1'b1, 8'h20});
    `CHK(fw_cnt, k + 1)
    `CHK(fw_last, 8'h1A)
    bus(1'b0, TXS_A_ACC, 32'h0, 4'hF, v);
    `CHK(v[7:0], 8'hB5)
    // skip on zero operand, no skip otherwise; second pass with a two-word follower
    for (f = 0; f < 2; f++) begin
      wr(TXS_A_NEXTW, f);
      for (k = 0; k < 2; k++) begin
        wr(TXS_A_FREG, k * 7);
        run({TXS_OP_TST_HI, 1'b1, 8'h20});
        `CHK(v[TXS_ST_SKIP], k == 0)
      end
    end
    wr(TXS_A_NEXTW, 32'h0);
    // indexed offset only with extension on, access bit 0, address up to 95
    wr(TXS_A_BANK, 32'h05);
    for (k = 0; k < 4; k++) begin
      wr(TXS_A_CTRL, {31'h0, ix[k][9]});
      run({TXS_OP_XORF_HI, 1'b0, ix[k][8], ix[k][7:0]});
      `CHK(v[TXS_ST_ILO], k == 1)
      bus(1'b0, TXS_A_INSN, 32'h0, 4'hF, v);
      `CHK(v[27:16], fa[k])
    end
    // pointer arith: only the pointer-2 forms return, only when enabled
    for (k = 0; k < 4; k++) begin
      f = ret_cnt;
      wr(TXS_A_CTRL, {31'h0, fr[k][9]});
      run({TXS_OP_FSRARITH, fr[k][8], fr[k][7:0]});
      `CHK(ret_cnt, f + (k < 2))
    end
    finish_test();
  end
endmodule
